/* core/clock_multiplier_pkg.sv */
// Package: register map, field layouts, timing constants and carrier types
package clock_multiplier_pkg;

	// Register byte addresses on the APB bus
	localparam int          ADDR_W          = 8;
	localparam logic [7:0]  CTRL_ADDR       = 8'h00;
	localparam logic [7:0]  IRQ_STATUS_ADDR = 8'h04;
	localparam logic [7:0]  IRQ_CLEAR_ADDR  = 8'h08;
	localparam logic [7:0]  IRQ_ENABLE_ADDR = 8'h0c;
	localparam logic [7:0]  EXT_OSC_ADDR    = 8'h10;

	// Control register field positions
	localparam int ON_BIT    = 7;
	localparam int INIT_BIT  = 6;
	localparam int LOCK_BIT  = 5;
	localparam int SCALE_HI  = 4;
	localparam int SCALE_LO  = 2;
	localparam int SRC_HI    = 1;
	localparam int SRC_LO    = 0;

	// External oscillator register field positions
	localparam int MODE_HI   = 6;
	localparam int MODE_LO   = 4;
	localparam int FREQ_HI   = 2;
	localparam int FREQ_LO   = 0;

	// Reset values
	localparam logic [7:0] CTRL_RESET    = 8'h00;
	localparam logic [2:0] MODE_RESET    = 3'h0;
	localparam logic [2:0] FREQ_RESET    = 3'h0;
	localparam logic [1:0] IRQ_RESET     = 2'h0;

	// Input select codes
	localparam logic [1:0] SRC_INT_X2    = 2'h0;
	localparam logic [1:0] SRC_EXT_X2    = 2'h1;
	localparam logic [1:0] SRC_INT_ALT   = 2'h2;
	localparam logic [1:0] SRC_EXT_X4    = 2'h3;

	// Scale divisor: output pulses two of every n base periods
	localparam logic [2:0] DIV_UNITY     = 3'h2;
	localparam logic [2:0] SCALE_FIRST_FRAC = 3'h3;

	// External oscillator modes
	localparam logic [2:0] MODE_OFF      = 3'h0;
	localparam logic [2:0] MODE_CMOS     = 3'h2;
	localparam logic [2:0] MODE_CMOS_DIV = 3'h3;
	localparam logic [2:0] MODE_RC       = 3'h4;
	localparam logic [2:0] MODE_CAP      = 3'h5;
	localparam logic [2:0] MODE_XTAL     = 3'h6;
	localparam logic [2:0] MODE_XTAL_DIV = 3'h7;

	// Lock must hold this long before ready is reported
	localparam int CLK_PERIOD_NS   = 50;
	localparam int LOCK_SETTLE_NS  = 1000;
	localparam int LOCK_SETTLE_CYC = (LOCK_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] SETTLE_LAST = 8'(LOCK_SETTLE_CYC - 1);

	// Interrupt bit positions
	localparam int IRQ_LOCKED_BIT = 0;
	localparam int IRQ_LOST_BIT   = 1;

	// Control register image
	typedef struct packed {
		logic       on;
		logic       init;
		logic       lock;
		logic [2:0] scale;
		logic [1:0] src;
	} ctrl_t;

	// Multiplier drive bundle
	typedef struct packed {
		logic enable;
		logic init;
		logic src_ext;
		logic times4;
	} pll_drive_t;

endpackage

/* core/output_scaler.sv */
// Output scaler: passes two of every n base periods of the multiplier output
module output_scaler
	import clock_multiplier_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       rst_b_in,
	input  wire logic       run_in,
	input  wire logic [2:0] divisor_in,
	output logic            scaled_clk_out
);

	logic [2:0] count_q;
	logic [2:0] count_d;
	logic       level_q;
	logic       level_d;
	logic [2:0] high_len;
	logic       wrap;

	// High for floor(n/2) of n; odd n gives uneven duty
	assign high_len = divisor_in >> 1;
	assign wrap     = (count_q >= divisor_in - 3'h1);
	assign count_d  = (!run_in || wrap) ? 3'h0 : count_q + 3'h1;
	assign level_d  = run_in && (count_d < high_len);

	// Phase counter and output level
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			count_q <= 3'h0;
			level_q <= 1'b0;
		end else begin
			count_q <= count_d;
			level_q <= level_d;
		end
	end

	assign scaled_clk_out = level_q;

endmodule

/* core/clock_multiplier_control.sv */
// Clock multiplier control: APB registers, init sequence, lock tracking and scaling
//
// Local design decisions: the APB register port and the address map.
module clock_multiplier_control
	import clock_multiplier_pkg::*;
(
	input  wire logic              clk_in,
	input  wire logic              rst_b_in,
	input  wire logic              psel_in,
	input  wire logic              penable_in,
	input  wire logic              pwrite_in,
	input  wire logic [ADDR_W-1:0] paddr_in,
	input  wire logic [31:0]       pwdata_in,
	output logic [31:0]            prdata_out,
	output logic                   pready_out,
	output logic                   pslverr_out,
	input  wire logic              pll_lock_in,
	output logic                   pll_enable_out,
	output logic                   pll_init_out,
	output logic                   pll_src_ext_out,
	output logic                   pll_times4_out,
	output logic                   scaled_clk_out,
	output logic                   osc_input_pin_claim_out,
	output logic                   osc_output_pin_claim_out,
	output logic [2:0]             ext_osc_freq_field_out,
	output logic                   irq_out
);

	typedef enum logic [2:0] {
		ST_OFF,
		ST_ARMED,
		ST_INIT,
		ST_WAIT_LOCK,
		ST_READY
	} mul_state_t;

	// Register state
	ctrl_t      ctrl_q;
	ctrl_t      ctrl_d;
	logic [2:0] mode_q;
	logic [2:0] freq_q;
	logic [1:0] irq_status_q;
	logic [1:0] irq_status_d;
	logic [1:0] irq_enable_q;
	logic [31:0] prdata_q;
	logic        pslverr_q;

	// Sequencer state
	mul_state_t  state_q;
	mul_state_t  state_d;
	logic [7:0]  settle_q;
	logic [7:0]  settle_d;
	pll_drive_t  drive_q;
	pll_drive_t  drive_d;

	// Lock input synchroniser
	logic lock_meta_q;
	logic lock_sync_q;

	// Ready edge tracking for interrupt events
	logic ready_prev_q;

	// Bus decode
	logic setup_phase;
	logic access_phase;
	logic wr_en;
	logic hit_ctrl;
	logic hit_status;
	logic hit_clear;
	logic hit_enable;
	logic hit_ext;
	logic addr_ok;
	logic wr_ctrl;
	logic wr_clear;
	logic wr_enable;
	logic wr_ext;
	ctrl_t wr_ctrl_val;

	// Derived behaviour
	logic       is_ready;
	logic       init_reads_one;
	logic       init_req;
	logic       ev_locked;
	logic       ev_lost;
	logic [1:0] irq_set;
	logic [1:0] irq_clr;
	logic [2:0] divisor;
	logic       times4;
	logic       src_ext;
	ctrl_t      ctrl_view;
	logic [7:0] ext_view;
	logic [31:0] rd_mux;

	// APB phase and address decode
	// Status register is read-only: a write to it hits but changes nothing
	assign setup_phase  = psel_in && !penable_in;
	assign access_phase = psel_in && penable_in;
	assign wr_en        = access_phase && pwrite_in && addr_ok;
	assign hit_ctrl     = (paddr_in == CTRL_ADDR);
	assign hit_status   = (paddr_in == IRQ_STATUS_ADDR);
	assign hit_clear    = (paddr_in == IRQ_CLEAR_ADDR);
	assign hit_enable   = (paddr_in == IRQ_ENABLE_ADDR);
	assign hit_ext      = (paddr_in == EXT_OSC_ADDR);
	assign addr_ok      = hit_ctrl || hit_status || hit_clear || hit_enable || hit_ext;
	assign wr_ctrl      = wr_en && hit_ctrl;
	assign wr_clear     = wr_en && hit_clear;
	assign wr_enable    = wr_en && hit_enable;
	assign wr_ext       = wr_en && hit_ext;
	assign wr_ctrl_val  = ctrl_t'(pwdata_in[7:0]);

	// Init only honoured when enable was already set before this write
	// Enable and init in one write is refused; enable must come first
	assign init_req = wr_ctrl && wr_ctrl_val.init && wr_ctrl_val.on && ctrl_q.on;

	// Base select: code 10 runs from the internal source at x2
	assign src_ext = (ctrl_q.src == SRC_EXT_X2) || (ctrl_q.src == SRC_EXT_X4);
	assign times4  = (ctrl_q.src == SRC_EXT_X4);

	// Scale divisor; x2 bases and the low codes pass unscaled
	assign divisor = (!times4 || ctrl_q.scale < SCALE_FIRST_FRAC) ? DIV_UNITY : ctrl_q.scale;

	// Status visible to software
	// Init reads one from the init strobe until enable is cleared
	assign is_ready       = (state_q == ST_READY);
	assign init_reads_one = (state_q == ST_INIT) || (state_q == ST_WAIT_LOCK) || is_ready;

	// Software view of the control register
	always_comb begin
		ctrl_view      = ctrl_q;
		ctrl_view.init = init_reads_one;
		ctrl_view.lock = is_ready;
	end

	// External oscillator register view
	assign ext_view = {1'b0, mode_q, 1'b0, freq_q};

	// Read data select; write-only clear reads zero
	assign rd_mux = hit_ctrl   ? {24'h000000, ctrl_view} :
	                hit_status ? {30'h00000000, irq_status_q} :
	                hit_enable ? {30'h00000000, irq_enable_q} :
	                hit_ext    ? {24'h000000, ext_view} : 32'h00000000;

	// Control register next value; lock bit is never stored
	// Init is a strobe: it starts the sequencer and is not kept
	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_ctrl) begin
			ctrl_d       = wr_ctrl_val;
			ctrl_d.init  = 1'b0;
			ctrl_d.lock  = 1'b0;
		end
	end

	// Control register
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			ctrl_q <= ctrl_t'(CTRL_RESET);
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// External oscillator mode and frequency fields
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			mode_q <= MODE_RESET;
			freq_q <= FREQ_RESET;
		end else if (wr_ext) begin
			mode_q <= pwdata_in[MODE_HI:MODE_LO];
			freq_q <= pwdata_in[FREQ_HI:FREQ_LO];
		end
	end

	// Read data captured in setup, error flag for unmapped addresses
	// Zero wait states, so read data is fixed at the setup edge
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			prdata_q  <= 32'h00000000;
			pslverr_q <= 1'b0;
		end else if (setup_phase) begin
			prdata_q  <= pwrite_in ? 32'h00000000 : rd_mux;
			pslverr_q <= !addr_ok;
		end
	end

	assign prdata_out  = prdata_q;
	assign pready_out  = 1'b1;
	assign pslverr_out = pslverr_q && access_phase;

	// Two-stage synchroniser on the lock pin
	// Lock comes from the analog loop with no relation to clk_in
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			lock_meta_q <= 1'b0;
			lock_sync_q <= 1'b0;
		end else begin
			lock_meta_q <= pll_lock_in;
			lock_sync_q <= lock_meta_q;
		end
	end

	// Enable, init and lock sequencer
	always_comb begin
		state_d  = state_q;
		settle_d = settle_q;
		case (state_q)
			ST_OFF: begin
				if (ctrl_q.on) begin
					state_d = ST_ARMED;
				end
			end
			ST_ARMED: begin
				if (init_req) begin
					state_d = ST_INIT;
				end
			end
			ST_INIT: begin
				settle_d = 8'h00;
				state_d  = ST_WAIT_LOCK;
			end
			// Settle count restarts whenever lock drops
			ST_WAIT_LOCK: begin
				if (!lock_sync_q) begin
					settle_d = 8'h00;
				end else if (settle_q == SETTLE_LAST) begin
					state_d = ST_READY;
				end else begin
					settle_d = settle_q + 8'h01;
				end
			end
			ST_READY: begin
				if (!lock_sync_q) begin
					settle_d = 8'h00;
					state_d  = ST_WAIT_LOCK;
				end
			end
			default: begin
				state_d = ST_OFF;
			end
		endcase
		// Re-init while running restarts the whole sequence
		if (state_q != ST_ARMED && state_q != ST_OFF && init_req) begin
			state_d = ST_INIT;
		end
		// Clearing enable overrides all; ready drops at that edge
		if (!ctrl_d.on) begin
			state_d  = ST_OFF;
			settle_d = 8'h00;
		end
	end

	// Sequencer registers
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			state_q  <= ST_OFF;
			settle_q <= 8'h00;
		end else begin
			state_q  <= state_d;
			settle_q <= settle_d;
		end
	end

	// Drive to the analog multiplier
	// INIT lasts one cycle, so the init output is a one-cycle pulse
	always_comb begin
		drive_d         = '0;
		drive_d.enable  = ctrl_q.on;
		drive_d.init    = (state_q == ST_INIT);
		drive_d.src_ext = src_ext;
		drive_d.times4  = times4;
	end

	// Registered multiplier drive
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			drive_q <= '0;
		end else begin
			drive_q <= drive_d;
		end
	end

	// All four drive lines change together, one cycle after the register
	assign pll_enable_out  = drive_q.enable;
	assign pll_init_out    = drive_q.init;
	assign pll_src_ext_out = drive_q.src_ext;
	assign pll_times4_out  = drive_q.times4;

	// Scaled output runs only while ready
	// A divisor change to at or below the current count wraps the phase counter at once
	output_scaler u_scaler (
		.clk_in         (clk_in),
		.rst_b_in       (rst_b_in),
		.run_in         (is_ready),
		.divisor_in     (divisor),
		.scaled_clk_out (scaled_clk_out)
	);

	// Oscillator pin ownership by mode
	// Claims follow the mode field directly so pins change with the write
	assign osc_input_pin_claim_out  = (mode_q == MODE_XTAL) || (mode_q == MODE_XTAL_DIV);
	assign osc_output_pin_claim_out = (mode_q != MODE_OFF);
	assign ext_osc_freq_field_out   = freq_q;

	// Ready edges raise interrupt events
	// Losing ready, by lock loss or disable, is an event too
	assign ev_locked = is_ready && !ready_prev_q;
	assign ev_lost   = !is_ready && ready_prev_q;
	assign irq_set   = {ev_lost, ev_locked};
	assign irq_clr   = wr_clear ? pwdata_in[1:0] : 2'h0;
	// Clear register is write-one-to-clear; zeros leave bits alone
	// Set wins over a simultaneous clear
	assign irq_status_d = (irq_status_q & ~irq_clr) | irq_set;

	// Interrupt status, enable and ready history
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			irq_status_q <= IRQ_RESET;
			irq_enable_q <= IRQ_RESET;
			ready_prev_q <= 1'b0;
		end else begin
			irq_status_q <= irq_status_d;
			ready_prev_q <= is_ready;
			if (wr_enable) begin
				irq_enable_q <= pwdata_in[1:0];
			end
		end
	end

	assign irq_out = |(irq_status_q & irq_enable_q);

endmodule

/* tb/clock_multiplier_control_asserts.sv */
// Port-level assertions for the clock multiplier control block
module clock_multiplier_control_asserts
	import clock_multiplier_pkg::*;
(
	input wire logic        clk_in,
	input wire logic        rst_b_in,
	input wire logic        psel_in,
	input wire logic        penable_in,
	input wire logic        pwrite_in,
	input wire logic [7:0]  paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [31:0] prdata_out,
	input wire logic        pready_out,
	input wire logic        pslverr_out,
	input wire logic        pll_lock_in,
	input wire logic        pll_enable_out,
	input wire logic        pll_init_out,
	input wire logic        pll_src_ext_out,
	input wire logic        pll_times4_out,
	input wire logic        scaled_clk_out,
	input wire logic        osc_input_pin_claim_out,
	input wire logic        osc_output_pin_claim_out,
	input wire logic [2:0]  ext_osc_freq_field_out,
	input wire logic        irq_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	wire logic cw;
	wire logic mapped;
	// Control write and address map decode
	assign cw = psel_in && penable_in && pwrite_in && paddr_in == CTRL_ADDR;
	assign mapped = paddr_in inside {CTRL_ADDR, IRQ_STATUS_ADDR, IRQ_CLEAR_ADDR, IRQ_ENABLE_ADDR, EXT_OSC_ADDR};

	en_follow_a: assert property (cw |-> ##2 pll_enable_out == $past(pwdata_in[7], 2))
		else $error("enable output differs from written bit");
	src_ext_a: assert property (cw |-> ##2 pll_src_ext_out == $past(pwdata_in[0], 2))
		else $error("external source output wrong");
	x4_sel_a: assert property (cw |-> ##2 pll_times4_out == ($past(pwdata_in[1:0], 2) == SRC_EXT_X4))
		else $error("times four output wrong");
	init_pulse_a: assert property (pll_init_out |=> !pll_init_out)
		else $error("init pulse longer than one cycle");
	init_en_a: assert property (pll_init_out |-> pll_enable_out)
		else $error("init pulse while disabled");
	idle_clk_a: assert property (!pll_lock_in [*8] |-> !scaled_clk_out)
		else $error("scaled clock runs without lock");
	off_clk_a: assert property (!pll_enable_out [*3] |-> !scaled_clk_out)
		else $error("scaled clock runs while disabled");
	claim_a: assert property (osc_input_pin_claim_out |-> osc_output_pin_claim_out)
		else $error("input pin claimed without output pin");
	bad_addr_a: assert property (psel_in && penable_in && !mapped |-> pslverr_out)
		else $error("no error on unmapped address");
	x2_plain_a: assert property (!pll_times4_out [*8] ##0 scaled_clk_out |=> !scaled_clk_out)
		else $error("times two base clock scaled");
	// Main scenarios
	cover property (pll_init_out);
	cover property ($rose(irq_out));
	cover property (pslverr_out);
endmodule

bind clock_multiplier_control clock_multiplier_control_asserts chk_u (
	.clk_in(clk_in), .rst_b_in(rst_b_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
	.paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
	.pslverr_out(pslverr_out), .pll_lock_in(pll_lock_in), .pll_enable_out(pll_enable_out),
	.pll_init_out(pll_init_out), .pll_src_ext_out(pll_src_ext_out), .pll_times4_out(pll_times4_out),
	.scaled_clk_out(scaled_clk_out), .osc_input_pin_claim_out(osc_input_pin_claim_out),
	.osc_output_pin_claim_out(osc_output_pin_claim_out), .ext_osc_freq_field_out(ext_osc_freq_field_out),
	.irq_out(irq_out));

/* tb/clock_multiplier_control_tb.sv */
// Self-checking bench for the clock multiplier control block
module clock_multiplier_control_tb
	import clock_multiplier_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {logic [7:0] a; logic [7:0] d; logic [6:0] o;} row_t;
	logic        clk_in = 1'b0;
	logic        rst_b_in = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic        lock = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, r;
	logic        pready, pslverr, e, pll_en, pll_init, src_ext, x4, sclk, in_cl, out_cl, irq;
	logic [2:0]  freq;
	int          err_count = 0;
	int          num_checks = 0;
	int          i, n, h;
	// Write, read back, expected {claims, source, times4, freq}
	row_t rows [11] = '{'{8'h10, 8'h65, 7'h65}, '{8'h10, 8'h70, 7'h60}, '{8'h10, 8'h42, 7'h22},
		'{8'h10, 8'h53, 7'h23}, '{8'h10, 8'h24, 7'h24}, '{8'h10, 8'h00, 7'h00}, '{8'h00, 8'h01, 7'h10},
		'{8'h00, 8'h02, 7'h00}, '{8'h00, 8'h03, 7'h18}, '{8'h00, 8'h1c, 7'h00}, '{8'h0c, 8'h03, 7'h00}};

	always #25 clk_in = ~clk_in;

	clock_multiplier_control DUT (.clk_in(clk_in), .rst_b_in(rst_b_in), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .pll_lock_in(lock), .pll_enable_out(pll_en), .pll_init_out(pll_init),
		.pll_src_ext_out(src_ext), .pll_times4_out(x4), .scaled_clk_out(sclk),
		.osc_input_pin_claim_out(in_cl), .osc_output_pin_claim_out(out_cl),
		.ext_osc_freq_field_out(freq), .irq_out(irq));

	task automatic end_sim();
		$display("checks=%0d errors=%0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic hang();
		err_count++;
		end_sim();
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		num_checks++;
		if (g !== x) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask

	// One APB transfer; read data and error taken at the pready edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_in);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_in);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_in);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (pready !== 1'b1)
			hang();
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Count high samples of the scaled clock after settling
	task automatic cnt(input int c);
		repeat (8) @(posedge clk_in);
		h = 0;
		repeat (c) begin
			@(posedge clk_in);
			h += int'(sclk);
		end
	endtask

	task automatic ready_wait();
		n = 0;
		do begin
			apb(1'b0, CTRL_ADDR, 0);
			n++;
		end while (r[5] !== 1'b1 && n < 100);
		if (r[5] !== 1'b1)
			hang();
	endtask

	initial begin
		repeat (6) @(posedge clk_in);
		rst_b_in <= 1'b1;
		// Reset values
		for (i = 0; i < 5; i++) begin
			if (i != 2) begin
				apb(1'b0, 8'(i * 4), 0);
				chk(r, 0);
			end
		end
		chk({pll_en, pll_init, sclk, irq, e}, 0);
		// Register and pin-claim table
		foreach (rows[k]) begin
			apb(1'b1, rows[k].a, 32'(rows[k].d));
			apb(1'b0, rows[k].a, 0);
			chk(r, 32'(rows[k].d));
			chk({in_cl, out_cl, src_ext, x4, freq}, 32'(rows[k].o));
		end
		// Init refused while off
		apb(1'b1, CTRL_ADDR, 32'h40);
		apb(1'b0, CTRL_ADDR, 0);
		chk(r, 0);
		// Bring-up with times four base
		apb(1'b1, EXT_OSC_ADDR, 32'h67);
		apb(1'b1, CTRL_ADDR, 32'h00);
		apb(1'b1, CTRL_ADDR, 32'h0f);
		apb(1'b1, CTRL_ADDR, 32'h8f);
		apb(1'b0, CTRL_ADDR, 0);
		chk(r, 32'h8f);
		chk(pll_en, 1);
		repeat (101) @(posedge clk_in);
		apb(1'b1, CTRL_ADDR, 32'hcf);
		n = 0;
		while (pll_init !== 1'b1) begin
			@(posedge clk_in);
			n++;
			if (n > 20)
				hang();
		end
		apb(1'b0, CTRL_ADDR, 0);
		chk(r[5], 0);
		lock <= 1'b1;
		ready_wait();
		chk(r, 32'hef);
		chk(irq, 1);
		// Every scale code, then each times two select
		for (i = 0; i < 11; i++) begin
			apb(1'b1, CTRL_ADDR, {24'h0, 3'b100, (i < 8) ? 3'(i) : 3'h7, (i < 8) ? 2'h3 : 2'(i - 8)});
			n = (i >= 3 && i < 8) ? i : 2;
			cnt(n * 4);
			chk(h, (n / 2) * 4);
		end
		// Lock loss, interrupt clear and mask
		lock <= 1'b0;
		repeat (10) @(posedge clk_in);
		apb(1'b0, CTRL_ADDR, 0);
		chk(r[5], 0);
		chk(sclk, 0);
		apb(1'b0, IRQ_STATUS_ADDR, 0);
		chk(r, 3);
		apb(1'b1, IRQ_CLEAR_ADDR, 3);
		apb(1'b0, IRQ_STATUS_ADDR, 0);
		chk(r, 0);
		chk(irq, 0);
		apb(1'b1, IRQ_ENABLE_ADDR, 0);
		lock <= 1'b1;
		ready_wait();
		chk(irq, 0);
		apb(1'b1, IRQ_ENABLE_ADDR, 1);
		@(posedge clk_in);
		chk(irq, 1);
		// Clearing the register drops ready
		apb(1'b1, CTRL_ADDR, 0);
		repeat (30) @(posedge clk_in);
		apb(1'b0, CTRL_ADDR, 0);
		chk(r, 0);
		chk(pll_en, 0);
		// Unmapped address
		apb(1'b1, 8'h14, 32'hff);
		chk(e, 1);
		apb(1'b0, 8'h14, 0);
		chk(e, 1);
		chk(r, 0);
		// Reset in mid-run clears the control and oscillator registers and five outputs
		apb(1'b1, EXT_OSC_ADDR, 32'h65);
		apb(1'b1, CTRL_ADDR, 32'h8f);
		rst_b_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		rst_b_in <= 1'b1;
		apb(1'b0, CTRL_ADDR, 0);
		chk(r, 0);
		apb(1'b0, EXT_OSC_ADDR, 0);
		chk(r, 0);
		chk({pll_en, in_cl, out_cl, irq, x4}, 0);
		end_sim();
	end
endmodule
